// file: shared/scfd_dec_if.sv
// interface: opcode byte in, decoded class out
`timescale 1ns/10ps
interface scfd_dec_if;
  import scfd_pkg::*;
  logic [7:0] op_byte;
  logic       escaped;
  scfd_op_t   op_class;
  modport core (output op_byte, output escaped, input op_class);
  modport cls  (input op_byte, input escaped, output op_class);
endinterface

// file: shared/scfd_pkg.sv
// package: opcodes, clock counts and types of the decode slice
package scfd_pkg;
  localparam logic [7:0] OPC_ESCAPE     = 8'h0F;
  localparam logic [7:0] OPC_SET_LT     = 8'h9C;
  localparam logic [7:0] OPC_SET_GE     = 8'h9D;
  localparam logic [7:0] OPC_SET_LE     = 8'h9E;
  localparam logic [7:0] OPC_SET_GT     = 8'h9F;
  localparam logic [7:0] OPC_FRAME_MAKE = 8'hC8;
  localparam logic [7:0] OPC_FRAME_DROP = 8'hC9;
  localparam logic [7:0] OPC_INT_VEC    = 8'hCD;
  localparam logic [7:0] OPC_INT_BRK    = 8'hCC;
  localparam logic [7:0] OPC_INT_OVF    = 8'hCE;
  localparam logic [7:0] OPC_RANGE_CHK  = 8'h62;
  localparam logic [7:0] OPC_TRAP_RET   = 8'hCF;
  localparam logic [2:0] MODRM_REG_SET  = 3'h0;
  localparam logic [1:0] MODRM_MOD_REG  = 2'h3;
  localparam logic [7:0] VEC_BRK        = 8'h03;
  localparam logic [7:0] VEC_OVF        = 8'h04;
  localparam logic [7:0] VEC_RANGE      = 8'h05;
  localparam logic [7:0] VEC_GP         = 8'h0D;
  localparam logic [16:0] SEG_LIMIT_MAX = 17'h0FFFF;
  localparam int CW = 12;
  localparam logic [CW-1:0] CLK_SET_REG     = 12'h004;
  localparam logic [CW-1:0] CLK_SET_MEM     = 12'h005;
  localparam logic [CW-1:0] CLK_ENTER_L0    = 12'h00A;
  localparam logic [CW-1:0] CLK_ENTER_L1    = 12'h00E;
  localparam logic [CW-1:0] CLK_ENTER_BASE  = 12'h011;
  localparam logic [CW-1:0] CLK_ENTER_STEP  = 12'h008;
  localparam logic [CW-1:0] CLK_LEAVE       = 12'h004;
  localparam logic [CW-1:0] CLK_INT_REAL    = 12'h025;
  localparam logic [CW-1:0] CLK_BRK_REAL    = 12'h021;
  localparam logic [CW-1:0] CLK_OVF_REAL    = 12'h023;
  localparam logic [CW-1:0] CLK_OVF_NONE    = 12'h003;
  localparam logic [CW-1:0] CLK_RANGE_OUT   = 12'h02C;
  localparam logic [CW-1:0] CLK_RANGE_IN    = 12'h00A;
  localparam logic [CW-1:0] CLK_GATE_SAME   = 12'h047;
  localparam logic [CW-1:0] CLK_GATE_PRIV   = 12'h06F;
  localparam logic [CW-1:0] CLK_INT_TSS16   = 12'h1B6;
  localparam logic [CW-1:0] CLK_INT_TSS32   = 12'h1D1;
  localparam logic [CW-1:0] CLK_BRK_TSS16   = 12'h17E;
  localparam logic [CW-1:0] CLK_BRK_TSS32   = 12'h199;
  localparam logic [CW-1:0] CLK_OVF_TSS16   = 12'h180;
  localparam logic [CW-1:0] CLK_OVF_TSS32   = 12'h19B;
  localparam logic [CW-1:0] CLK_RNG_TSS16   = 12'h166;
  localparam logic [CW-1:0] CLK_RNG_TSS32   = 12'h184;
  localparam logic [CW-1:0] CLK_V86_INT_PL0 = 12'h113;
  localparam logic [CW-1:0] CLK_V86_EXC_PL0 = 12'h0DF;
  localparam logic [CW-1:0] CLK_TRAP_RET    = 12'h00A;
  localparam logic [CW-1:0] CLK_FAULT       = 12'h001;

  typedef enum logic [1:0] {
    MODE_REAL,
    MODE_V86,
    MODE_PROT
  } scfd_mode_t;

  typedef enum logic [3:0] {
    OP_NONE,
    OP_ESCAPE,
    OP_SET_BYTE_IF_SIGNED_LESS,
    OP_SET_BYTE_IF_SIGNED_NOT_LESS,
    OP_SET_BYTE_IF_SIGNED_LE,
    OP_SET_BYTE_IF_SIGNED_GT,
    OP_FRAME_MAKE,
    OP_FRAME_DROP,
    OP_INT_VEC,
    OP_INT_BRK,
    OP_INT_OVF,
    OP_RANGE_CHK,
    OP_TRAP_RETURN
  } scfd_op_t;
endpackage

// file: src/scfd_classify.sv
// combinational opcode classifier
`timescale 1ns/10ps
module scfd_classify
  import scfd_pkg::*;
(
  scfd_dec_if.cls dec
);
  always_comb begin
    dec.op_class = OP_NONE;
    if (dec.escaped) begin
      unique case (dec.op_byte)
        // [RULE1] signed less set
        OPC_SET_LT: dec.op_class = OP_SET_BYTE_IF_SIGNED_LESS;
        OPC_SET_GE: dec.op_class = OP_SET_BYTE_IF_SIGNED_NOT_LESS;
        // [RULE2] signed le set
        OPC_SET_LE: dec.op_class = OP_SET_BYTE_IF_SIGNED_LE;
        // [RULE3] signed gt set
        OPC_SET_GT: dec.op_class = OP_SET_BYTE_IF_SIGNED_GT;
        default:    dec.op_class = OP_NONE;
      endcase
    end else begin
      unique case (dec.op_byte)
        OPC_ESCAPE:     dec.op_class = OP_ESCAPE;
        // [RULE4] frame build opcode
        OPC_FRAME_MAKE: dec.op_class = OP_FRAME_MAKE;
        // [RULE5] frame teardown opcode
        OPC_FRAME_DROP: dec.op_class = OP_FRAME_DROP;
        // [RULE6] explicit vector interrupt
        OPC_INT_VEC:    dec.op_class = OP_INT_VEC;
        // [RULE7] breakpoint opcode
        OPC_INT_BRK:    dec.op_class = OP_INT_BRK;
        // [RULE8] overflow trap opcode
        OPC_INT_OVF:    dec.op_class = OP_INT_OVF;
        // [RULE9] range check opcode
        OPC_RANGE_CHK:  dec.op_class = OP_RANGE_CHK;
        // [RULE13] trap return opcode
        OPC_TRAP_RET:   dec.op_class = OP_TRAP_RETURN;
        default:        dec.op_class = OP_NONE;
      endcase
    end
  end
endmodule // scfd_classify

// file: src/scfd_decode.sv
// decode and sequencing of byte-set, frame, interrupt and trap return
// How it works
// [RULE1] escape then 9C: signed less set, 4/5
// [RULE2] escape then 9E: signed le set, 4/5
// [RULE3] escape then 9F: signed gt set, 4/5
// [RULE4] C8 frame build: 10 or 14 clocks
// [RULE5] C9 frame teardown: always 4 clocks
// [RULE6] CD vector interrupt: 37 clocks real/v86
// [RULE7] CC breakpoint to vector 3: 33 clocks
// [RULE8] CE: overflow gives vector 4 35, else 3
// [RULE9] 62 range check: out 44 vector 5, in 10
// [RULE10] protected gate dispatch: 71 same, 111 change
// [RULE11] vector task switch: 438 or 465 clocks
// [RULE12] v86 to level 0: 275 or 223
// [RULE13] CF decodes as trap return
// [RULE14] real mode beyond FFFF raises vector 13
// [RULE15] overflow trap, range check fault by value
// [RULE16] set byte writes 1 or 0, flags kept
// [RULE17] deeper frame nesting adds clocks per level
`timescale 1ns/10ps
module scfd_decode
  import scfd_pkg::*;
(
  input  wire logic       mclk_in,
  input  wire logic       srst_in,
  input  wire logic [7:0] fetch_byte_in,
  input  wire logic       fetch_valid_in,
  output logic            fetch_ready_out,
  input  wire scfd_mode_t mode_in,
  input  wire logic       sign_flag_in,
  input  wire logic       zero_flag_in,
  input  wire logic       overflow_flag_in,
  input  wire logic       range_ok_in,
  input  wire logic       gate_priv_change_in,
  input  wire logic       gate_task_in,
  input  wire logic       task_state_segment_32_in,
  input  wire logic       v86_gate_pl0_in,
  input  wire logic [15:0] ea_offset_in,
  output scfd_op_t        op_out,
  output logic            busy_out,
  output logic            done_out,
  output logic            result_wr_out,
  output logic            result_mem_out,
  output logic [7:0]      result_out,
  output logic [15:0]     frame_size_out,
  output logic [7:0]      frame_level_out,
  output logic            int_raise_out,
  output logic [7:0]      int_vector_out
);
  typedef enum logic [2:0] {
    ST_OPCODE,
    ST_OP2,
    ST_MODRM,
    ST_IMM_LO,
    ST_IMM_HI,
    ST_LEVEL,
    ST_VECTOR,
    ST_EXEC
  } scfd_state_t;

  typedef struct packed {
    scfd_state_t     st;
    scfd_op_t        op;
    logic [CW-1:0]   cnt;
    logic            mem;
    logic [15:0]     size;
    logic [7:0]      level;
    logic [7:0]      vec;
    logic            raise;
    logic [7:0]      res;
    logic            wr;
    logic            done;
  } scfd_regs_t;

  scfd_regs_t  cur_ff;
  scfd_regs_t  nxt_cur;
  scfd_dec_if  dec ();

  scfd_classify u_classify (
    .dec (dec)
  );

  assign dec.op_byte = fetch_byte_in;
  assign dec.escaped = (cur_ff.st == ST_OP2);
  assign fetch_ready_out = (cur_ff.st != ST_EXEC);

  logic            take;
  logic            lt_sig;
  logic            cond;
  logic [16:0]     ea_last;
  logic            seg_over;
  logic            is_set;
  logic [CW-1:0]   enter_clks;

  assign take    = fetch_valid_in && fetch_ready_out;
  assign lt_sig  = sign_flag_in ^ overflow_flag_in;
  assign is_set  = (cur_ff.op == OP_SET_BYTE_IF_SIGNED_LESS) ||
                   (cur_ff.op == OP_SET_BYTE_IF_SIGNED_NOT_LESS) ||
                   (cur_ff.op == OP_SET_BYTE_IF_SIGNED_LE) ||
                   (cur_ff.op == OP_SET_BYTE_IF_SIGNED_GT);
  // [RULE14] last byte of operand
  assign ea_last = {1'b0, ea_offset_in} + (cur_ff.op == OP_RANGE_CHK ? 17'h00003 : 17'h00000);
  assign seg_over = (mode_in == MODE_REAL) && (ea_last > SEG_LIMIT_MAX);
  // [RULE17] linear growth per level
  assign enter_clks = CLK_ENTER_BASE + CLK_ENTER_STEP * (CW'(fetch_byte_in) - 12'h001);

  // [RULE16] condition per byte-set form
  always_comb begin
    unique case (cur_ff.op)
      OP_SET_BYTE_IF_SIGNED_LESS:     cond = lt_sig;
      OP_SET_BYTE_IF_SIGNED_NOT_LESS: cond = !lt_sig;
      OP_SET_BYTE_IF_SIGNED_LE:       cond = zero_flag_in || lt_sig;
      default:                        cond = !(zero_flag_in || lt_sig);
    endcase
  end

  // [RULE10] gate and task dispatch cost
  function automatic logic [CW-1:0] prot_clks(input logic [CW-1:0] t16,
                                              input logic [CW-1:0] t32);
    logic [CW-1:0] r;
    r = gate_priv_change_in ? CLK_GATE_PRIV : CLK_GATE_SAME;
    if (gate_task_in) begin
      r = task_state_segment_32_in ? t32 : t16;
    end
    return r;
  endfunction

  // exception dispatch cost by mode
  function automatic logic [CW-1:0] exc_clks(input logic [CW-1:0] real_c,
                                             input logic [CW-1:0] v86_c,
                                             input logic [CW-1:0] t16,
                                             input logic [CW-1:0] t32);
    logic [CW-1:0] r;
    r = real_c;
    if (mode_in == MODE_PROT) begin
      r = prot_clks(t16, t32);
    end else if (mode_in == MODE_V86 && v86_gate_pl0_in) begin
      r = v86_c;
    end
    return r;
  endfunction

  always_comb begin
    nxt_cur      = cur_ff;
    nxt_cur.done = 1'b0;
    nxt_cur.wr   = 1'b0;
    unique case (cur_ff.st)
      ST_OPCODE: begin
        nxt_cur.raise = 1'b0;
        if (take) begin
          nxt_cur.op = dec.op_class;
          unique case (dec.op_class)
            OP_ESCAPE:      nxt_cur.st = ST_OP2;
            OP_FRAME_MAKE:  nxt_cur.st = ST_IMM_LO;
            OP_INT_VEC:     nxt_cur.st = ST_VECTOR;
            OP_RANGE_CHK:   nxt_cur.st = ST_MODRM;
            // [RULE5] teardown fixed cost
            OP_FRAME_DROP: begin
              nxt_cur.st  = ST_EXEC;
              nxt_cur.cnt = CLK_LEAVE;
            end
            // [RULE7] breakpoint vector 3
            OP_INT_BRK: begin
              nxt_cur.st    = ST_EXEC;
              nxt_cur.vec   = VEC_BRK;
              nxt_cur.raise = 1'b1;
              // [RULE12] breakpoint from v86
              nxt_cur.cnt   = exc_clks(CLK_BRK_REAL, CLK_V86_EXC_PL0,
                                       CLK_BRK_TSS16, CLK_BRK_TSS32);
            end
            // [RULE8] overflow decides trap
            OP_INT_OVF: begin
              nxt_cur.st    = ST_EXEC;
              nxt_cur.vec   = VEC_OVF;
              // [RULE15] trap by flag value
              nxt_cur.raise = overflow_flag_in;
              nxt_cur.cnt   = overflow_flag_in ?
                              exc_clks(CLK_OVF_REAL, CLK_V86_EXC_PL0,
                                       CLK_OVF_TSS16, CLK_OVF_TSS32) : CLK_OVF_NONE;
            end
            // [RULE13] trap return sequence
            OP_TRAP_RETURN: begin
              nxt_cur.st  = ST_EXEC;
              nxt_cur.cnt = CLK_TRAP_RET;
            end
            default:        nxt_cur.st = ST_OPCODE;
          endcase
        end
      end
      ST_OP2: begin
        if (take) begin
          nxt_cur.op = dec.op_class;
          nxt_cur.st = (dec.op_class == OP_NONE) ? ST_OPCODE : ST_MODRM;
        end
      end
      ST_MODRM: begin
        if (take) begin
          nxt_cur.mem = (fetch_byte_in[7:6] != MODRM_MOD_REG);
          nxt_cur.st  = ST_EXEC;
          if (is_set) begin
            // [RULE1] register 4, memory 5
            nxt_cur.cnt = (fetch_byte_in[7:6] != MODRM_MOD_REG) ? CLK_SET_MEM : CLK_SET_REG;
            if (fetch_byte_in[5:3] != MODRM_REG_SET) begin
              nxt_cur.st = ST_OPCODE;
            end
          end else begin
            // [RULE9] out of range raises vector 5
            nxt_cur.vec   = VEC_RANGE;
            nxt_cur.raise = !range_ok_in;
            // [RULE12] range check from v86
            nxt_cur.cnt   = range_ok_in ? CLK_RANGE_IN :
                            exc_clks(CLK_RANGE_OUT, CLK_V86_EXC_PL0,
                                     CLK_RNG_TSS16, CLK_RNG_TSS32);
          end
          // [RULE14] segment limit fault
          if ((fetch_byte_in[7:6] != MODRM_MOD_REG) && seg_over &&
              (nxt_cur.st == ST_EXEC)) begin
            nxt_cur.vec   = VEC_GP;
            nxt_cur.raise = 1'b1;
            nxt_cur.cnt   = CLK_FAULT;
          end
        end
      end
      ST_IMM_LO: begin
        if (take) begin
          nxt_cur.size[7:0] = fetch_byte_in;
          nxt_cur.st        = ST_IMM_HI;
        end
      end
      ST_IMM_HI: begin
        if (take) begin
          nxt_cur.size[15:8] = fetch_byte_in;
          nxt_cur.st         = ST_LEVEL;
        end
      end
      ST_LEVEL: begin
        if (take) begin
          nxt_cur.level = fetch_byte_in;
          nxt_cur.st    = ST_EXEC;
          // [RULE4] level zero and one
          if (fetch_byte_in == 8'h00) begin
            nxt_cur.cnt = CLK_ENTER_L0;
          end else if (fetch_byte_in == 8'h01) begin
            nxt_cur.cnt = CLK_ENTER_L1;
          end else begin
            nxt_cur.cnt = enter_clks;
          end
        end
      end
      ST_VECTOR: begin
        if (take) begin
          nxt_cur.vec   = fetch_byte_in;
          nxt_cur.raise = 1'b1;
          nxt_cur.st    = ST_EXEC;
          // [RULE6] real 37, [RULE11] task switch
          nxt_cur.cnt   = exc_clks(CLK_INT_REAL, CLK_V86_INT_PL0,
                                   CLK_INT_TSS16, CLK_INT_TSS32);
        end
      end
      ST_EXEC: begin
        nxt_cur.cnt = cur_ff.cnt - 12'h001;
        if (cur_ff.cnt == 12'h001) begin
          nxt_cur.st   = ST_OPCODE;
          nxt_cur.done = 1'b1;
          // [RULE16] byte value, no flag write
          if (is_set && !cur_ff.raise) begin
            nxt_cur.res = {7'h00, cond};
            nxt_cur.wr  = 1'b1;
          end
        end
      end
    endcase
  end

  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      cur_ff <= '{st: ST_OPCODE, op: OP_NONE, default: '0};
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  assign op_out          = cur_ff.op;
  assign busy_out        = (cur_ff.st == ST_EXEC);
  assign done_out        = cur_ff.done;
  assign result_wr_out   = cur_ff.wr;
  assign result_mem_out  = cur_ff.mem;
  assign result_out      = cur_ff.res;
  assign frame_size_out  = cur_ff.size;
  assign frame_level_out = cur_ff.level;
  assign int_raise_out   = cur_ff.done && cur_ff.raise;
  assign int_vector_out  = cur_ff.vec;
endmodule // scfd_decode

// file: tb/scfd_decode_assertions.sv
// checker: decode slice counts and results
`timescale 1ns/10ps
module scfd_decode_assertions
  import scfd_pkg::*;
(
  input wire logic       mclk_in,
  input wire logic       srst_in,
  input wire scfd_mode_t mode_in,
  input wire logic       sign_flag_in,
  input wire logic       zero_flag_in,
  input wire logic       overflow_flag_in,
  input wire logic       fetch_ready_out,
  input wire scfd_op_t   op_out,
  input wire logic       busy_out,
  input wire logic       done_out,
  input wire logic       result_wr_out,
  input wire logic [7:0] result_out,
  input wire logic [7:0] frame_level_out,
  input wire logic       int_raise_out,
  input wire logic [7:0] int_vector_out
);
  logic [11:0] busy_len_ff;
  logic        busy_q_ff;
  always_ff @(posedge mclk_in) begin
    busy_q_ff   <= srst_in ? 1'b0 : busy_out;
    busy_len_ff <= srst_in ? 12'h000 : !busy_out ? busy_len_ff :
                   busy_q_ff ? busy_len_ff + 12'h001 : 12'h001;
  end
  default clocking @(posedge mclk_in); endclocking
  default disable iff (srst_in);
  brk_vector_a: assert property (done_out && op_out == OP_INT_BRK
    |-> int_raise_out && int_vector_out == 8'h03) else $error("breakpoint vector wrong");
  int_real_a: assert property (done_out && op_out == OP_INT_VEC && mode_in == MODE_REAL
    |-> busy_len_ff == 12'h025) else $error("vector interrupt count wrong");
  leave_count_a: assert property (done_out && op_out == OP_FRAME_DROP
    |-> busy_len_ff == 12'h004) else $error("frame teardown count wrong");
  frame_zero_a: assert property (done_out && op_out == OP_FRAME_MAKE && frame_level_out == 0
    |-> busy_len_ff == 12'h00A) else $error("frame build count wrong");
  frame_deep_a: assert property (done_out && op_out == OP_FRAME_MAKE && frame_level_out > 1
    |-> busy_len_ff == 12'h009 + {1'b0, frame_level_out, 3'b000}) else $error("deep frame count wrong");
  set_less_a: assert property (result_wr_out && op_out == OP_SET_BYTE_IF_SIGNED_LESS
    |-> result_out == {7'h00, $past(sign_flag_in) ^ $past(overflow_flag_in)})
    else $error("signed less result wrong");
  set_le_a: assert property (result_wr_out && op_out == OP_SET_BYTE_IF_SIGNED_LE
    |-> result_out == {7'h00, $past(zero_flag_in) | ($past(sign_flag_in) ^ $past(overflow_flag_in))})
    else $error("signed le result wrong");
  set_gt_a: assert property (result_wr_out && op_out == OP_SET_BYTE_IF_SIGNED_GT
    |-> result_out == {7'h00, !$past(zero_flag_in) && $past(sign_flag_in) == $past(overflow_flag_in)})
    else $error("signed gt result wrong");
  set_write_a: assert property (result_wr_out
    |-> done_out && !int_raise_out) else $error("byte set write without done");
  ovf_raise_a: assert property (done_out && op_out == OP_INT_OVF
    |-> int_raise_out == (busy_len_ff != 12'h003)) else $error("overflow trap raise wrong");
  fault_vec_a: assert property (done_out && int_raise_out && busy_len_ff == 12'h001
    |-> int_vector_out == 8'h0D) else $error("limit fault vector wrong");
  ready_busy_a: assert property (busy_out
    |-> !fetch_ready_out) else $error("byte taken while executing");
endmodule // scfd_decode_assertions
bind scfd_decode scfd_decode_assertions u_chk (.mclk_in, .srst_in, .mode_in, .sign_flag_in,
  .zero_flag_in, .overflow_flag_in, .fetch_ready_out, .op_out, .busy_out, .done_out,
  .result_wr_out,
  .result_out, .frame_level_out, .int_raise_out, .int_vector_out);

// file: tb/scfd_fetch_model.sv
// partner: instruction prefetch byte stream
`timescale 1ns/10ps
module scfd_fetch_model (
  input  wire logic       mclk_in,
  input  wire logic       srst_in,
  input  wire logic       fetch_ready_in,
  output logic [7:0]      fetch_byte_out,
  output logic            fetch_valid_out
);
  logic [7:0] q[$];
  int         cyc = 0;
  int         last_cyc = 0;
  int         stall = 0;
  int         gap = 0;
  initial begin
    fetch_valid_out = 1'b0;
    fetch_byte_out  = 8'h00;
  end
  always @(posedge mclk_in) begin
    cyc <= cyc + 1;
    if (srst_in) begin
      q.delete();
      gap = 0;
    end else if (fetch_valid_out && fetch_ready_in) begin
      void'(q.pop_front());
      last_cyc <= cyc;
      gap = stall;
    end else if (gap > 0) begin
      gap--;
    end
    if (q.size() > 0 && gap == 0 && !srst_in) begin
      fetch_valid_out <= 1'b1;
      fetch_byte_out  <= q[0];
    end else begin
      fetch_valid_out <= 1'b0;
      fetch_byte_out  <= ~fetch_byte_out;
    end
  end
endmodule // scfd_fetch_model

// file: tb/tb_setcc_frame_interrupt_decode.sv
// testbench: decode slice scenarios
`timescale 1ns/10ps
module tb_setcc_frame_interrupt_decode;
  import scfd_pkg::*;
  typedef logic [7:0] scfd_bq_t[$];
  logic mclk_in, srst_in, fetch_valid_in, fetch_ready_out, sign_flag_in, zero_flag_in;
  logic overflow_flag_in, range_ok_in, gate_priv_change_in, gate_task_in, v86_gate_pl0_in;
  logic task_state_segment_32_in, busy_out, done_out, result_wr_out, result_mem_out;
  logic int_raise_out;
  logic [7:0] fetch_byte_in, result_out, frame_level_out, int_vector_out, fl;
  logic [15:0] ea_offset_in, frame_size_out;
  scfd_mode_t mode_in;
  scfd_op_t   op_out;
  int miscompares = 0;
  int n_tests = 0;
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin miscompares++; \
  $display("mismatch t=%0t got=%0h exp=%0h", $time, (a), (e)); end end
  assign {sign_flag_in, zero_flag_in, overflow_flag_in, range_ok_in, gate_priv_change_in,
          gate_task_in, task_state_segment_32_in, v86_gate_pl0_in} = fl;
  scfd_decode u_dut (.mclk_in, .srst_in, .fetch_byte_in, .fetch_valid_in, .fetch_ready_out,
    .mode_in, .sign_flag_in, .zero_flag_in, .overflow_flag_in, .range_ok_in,
    .gate_priv_change_in, .gate_task_in, .task_state_segment_32_in, .v86_gate_pl0_in,
    .ea_offset_in, .op_out, .busy_out, .done_out, .result_wr_out, .result_mem_out,
    .result_out, .frame_size_out, .frame_level_out, .int_raise_out, .int_vector_out);
  scfd_fetch_model u_fetch (.mclk_in, .srst_in, .fetch_ready_in(fetch_ready_out),
    .fetch_byte_out(fetch_byte_in), .fetch_valid_out(fetch_valid_in));
  initial begin
    mclk_in = 1'b0;
    forever #5 mclk_in = ~mclk_in;
  end
  task automatic print_verdict();
    if (miscompares == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // flag order: sign zero ovf range_ok priv task tss32 pl0
  task automatic flags(input logic [7:0] f);
    @(posedge mclk_in) fl <= f;
  endtask
  // n is the clock count; 0 means no completion expected
  task automatic exec(input scfd_bq_t b, input int n);
    int k;
    @(posedge mclk_in) #1;
    u_fetch.q = b;
    for (k = 0; k < (n ? 600 : 40) && done_out !== 1'b1; k++) @(posedge mclk_in) #1;
    if (n == 0) `CHK(done_out, 1'b0)
    else `CHK(u_fetch.cyc - u_fetch.last_cyc, n + 1)
  endtask
  task automatic t_set();
    flags(8'h80);
    exec('{OPC_ESCAPE, OPC_SET_LT, 8'hC0}, 4);
    `CHK(result_out, 8'h01)
    exec('{OPC_ESCAPE, OPC_SET_GT, 8'h00}, 5);
    `CHK({result_mem_out, result_out}, 9'h100)
    flags(8'h40);
    exec('{OPC_ESCAPE, OPC_SET_LE, 8'h00}, 5);
    `CHK(result_out, 8'h01)
    exec('{OPC_ESCAPE, OPC_SET_LT, 8'hC0}, 4);
    `CHK(result_out, 8'h00)
    exec('{OPC_ESCAPE, OPC_SET_GT, 8'hC8}, 0);
  endtask
  task automatic t_frame();
    flags(8'h00);
    u_fetch.stall <= 2;
    exec('{OPC_FRAME_MAKE, 8'h34, 8'h12, 8'h00}, 10);
    `CHK({frame_size_out, frame_level_out}, 24'h123400)
    exec('{OPC_FRAME_MAKE, 8'h00, 8'h01, 8'h01}, 14);
    exec('{OPC_FRAME_MAKE, 8'hFF, 8'hFF, 8'h03}, 33);
    `CHK(frame_size_out, 16'hFFFF)
    u_fetch.stall = 0;
    for (int m = 0; m < 3; m++) begin
      @(posedge mclk_in) mode_in <= scfd_mode_t'(m);
      exec('{OPC_FRAME_DROP}, 4);
    end
  endtask
  task automatic t_real();
    @(posedge mclk_in) mode_in <= MODE_REAL;
    flags(8'h20);
    exec('{OPC_INT_VEC, 8'h41}, 37);
    `CHK({int_raise_out, int_vector_out}, 9'h141)
    exec('{OPC_INT_BRK}, 33);
    `CHK(int_vector_out, 8'h03)
    exec('{OPC_INT_OVF}, 35);
    `CHK({int_raise_out, int_vector_out}, 9'h104)
    flags(8'h10);
    exec('{OPC_INT_OVF}, 3);
    `CHK(int_raise_out, 1'b0)
    exec('{OPC_RANGE_CHK, 8'hC0}, 10);
    flags(8'h00);
    exec('{OPC_RANGE_CHK, 8'hC0}, 44);
    `CHK({int_raise_out, int_vector_out}, 9'h105)
    exec('{OPC_TRAP_RET}, 10);
    `CHK(op_out, OP_TRAP_RETURN)
  endtask
  task automatic t_prot();
    @(posedge mclk_in) mode_in <= MODE_PROT;
    flags(8'h00);
    exec('{OPC_INT_VEC, 8'h20}, 71);
    flags(8'h08);
    exec('{OPC_INT_VEC, 8'h21}, 111);
    exec('{OPC_INT_BRK}, 111);
    flags(8'h04);
    exec('{OPC_INT_VEC, 8'h22}, 438);
    flags(8'h06);
    exec('{OPC_INT_VEC, 8'h23}, 465);
    @(posedge mclk_in) mode_in <= MODE_V86;
    flags(8'h01);
    exec('{OPC_INT_VEC, 8'h24}, 275);
    exec('{OPC_INT_BRK}, 223);
    flags(8'h21);
    exec('{OPC_INT_OVF}, 223);
  endtask
  task automatic t_limit();
    @(posedge mclk_in) mode_in <= MODE_REAL;
    ea_offset_in <= 16'hFFFF;
    flags(8'h10);
    exec('{OPC_ESCAPE, OPC_SET_LT, 8'h00}, 5);
    exec('{OPC_RANGE_CHK, 8'h00}, 1);
    `CHK({int_raise_out, int_vector_out}, 9'h10D)
  endtask
  initial begin
    #100000;
    miscompares++;
    print_verdict();
  end
  initial begin
    srst_in = 1'b1;
    mode_in = MODE_REAL;
    ea_offset_in = 16'h0000;
    fl = 8'h00;
    repeat (2) @(posedge mclk_in);
    srst_in <= 1'b0;
    t_set();
    t_frame();
    t_real();
    t_prot();
    t_limit();
    print_verdict();
  end
endmodule // tb_setcc_frame_interrupt_decode
